//--- hw/mira_pkg.sv
// constants shared by both ends of the indirect mac register port
package mira_pkg;

  // ==========================================================
  // direct byte registers on the device's own parallel bus
  localparam logic [7:0] DEV_OFS_INDEX = 8'h0a;
  localparam logic [7:0] DEV_OFS_DATA_HIGH = 8'h0b;
  localparam logic [7:0] DEV_OFS_DATA_LOW = 8'h0c;
  localparam logic [7:0] DEV_OFS_TRIGGER = 8'h0d;
  localparam logic [7:0] DEV_BYTE_RST = 8'h00;

  // ==========================================================
  // indirect mac register indices and storage slots
  localparam int MAC_REG_COUNT = 9;
  localparam logic [7:0] IDX_CONTROL = 8'h00;
  localparam logic [7:0] IDX_CONFIG = 8'h01;
  localparam logic [7:0] IDX_B2B_GAP = 8'h02;
  localparam logic [7:0] IDX_NB2B_GAP = 8'h03;
  localparam logic [7:0] IDX_COLL_RETRY = 8'h04;
  localparam logic [7:0] IDX_MAX_LEN = 8'h05;
  localparam logic [7:0] IDX_STATION0 = 8'h10;
  localparam logic [7:0] IDX_STATION1 = 8'h11;
  localparam logic [7:0] IDX_STATION2 = 8'h12;
  localparam logic [3:0] SLOT_STATION0 = 4'h6;
  localparam logic [3:0] SLOT_NONE = 4'hf;
  localparam logic [15:0] CONTROL_RST = 16'h8000;
  localparam logic [15:0] OTHER_RST = 16'h0000;

  // ==========================================================
  // initialisation values written by the controller
  localparam logic [15:0] CFG_FULL = 16'h40b3;
  localparam logic [15:0] CFG_HALF = 16'h4012;
  localparam logic [15:0] B2B_FULL = 16'h0015;
  localparam logic [15:0] B2B_HALF = 16'h0012;
  localparam logic [15:0] NB2B_VALUE = 16'h0c12;
  localparam logic [15:0] MAX_LEN_VALUE = 16'h05ee;
  localparam logic [15:0] CTL_RCV_EN = 16'h0001;
  localparam int CTL_LOOPBACK_BIT = 4;
  localparam int CTL_TXPAUSE_BIT = 3;
  localparam int CTL_RXPAUSE_BIT = 2;
  localparam logic [2:0] INIT_LAST_OP = 3'h7;
  localparam logic [1:0] PHASE_LAST = 2'h3;

  // ==========================================================
  // controller apb register map and fields
  localparam logic [7:0] APB_CTRL = 8'h00;
  localparam logic [7:0] APB_CMD = 8'h04;
  localparam logic [7:0] APB_INDEX = 8'h08;
  localparam logic [7:0] APB_WDATA = 8'h0c;
  localparam logic [7:0] APB_RDATA = 8'h10;
  localparam logic [7:0] APB_STATUS = 8'h14;
  localparam logic [7:0] APB_STATION_HI = 8'h18;
  localparam logic [7:0] APB_STATION_LO = 8'h1c;
  localparam int CTRL_FULL_DUPLEX = 0;
  localparam int CTRL_AUTO_INIT = 1;
  localparam int CTRL_RXPAUSE = 2;
  localparam int CTRL_TXPAUSE = 3;
  localparam int CTRL_LOOPBACK = 4;
  localparam int CTRL_WIDTH = 5;
  localparam int CMD_INIT = 0;
  localparam int CMD_WRITE = 1;
  localparam int CMD_READ = 2;
  localparam int STAT_BUSY = 0;
  localparam int STAT_DONE = 1;
  localparam int STAT_MAC_READY = 2;

  // map an indirect index onto a storage slot, SLOT_NONE when unimplemented
  function automatic logic [3:0] mira_slot(input logic [7:0] idx);
    logic [3:0] s;
    s = SLOT_NONE;
    if (idx <= IDX_MAX_LEN) begin
      s = idx[3:0];
    end else if (idx >= IDX_STATION0 && idx <= IDX_STATION2) begin
      s = SLOT_STATION0 + idx[3:0];
    end
    return s;
  endfunction

endpackage

//--- hw/mira_if.sv
// parallel byte bus joining the controller to the device
`timescale 1ns/1ps
interface mira_if;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic [7:0] rdata;
  logic rvalid;

  // device end answers reads one cycle after the strobe
  modport dev (
    input addr,
    input wdata,
    input wr,
    input rd,
    output rdata,
    output rvalid
  );

  // controller end issues one-cycle strobes
  modport host (
    output addr,
    output wdata,
    output wr,
    output rd,
    input rdata,
    input rvalid
  );
endinterface

//--- hw/mira_dev.sv
// device end: direct byte registers and the nine indirect mac registers
`timescale 1ns/1ps
module mira_dev (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic ce,
  mira_if.dev bus,
  output logic [mira_pkg::MAC_REG_COUNT-1:0][15:0] mac_regs
);

  // ==========================================================
  // direct registers
  logic [7:0] indirect_index;
  logic [7:0] indirect_data_high;
  logic [7:0] indirect_data_low;
  logic [7:0] indirect_transfer_trigger;
  logic [3:0] sel_slot;
  logic sel_ok;
  logic [15:0] sel_value;
  logic trig_wr;
  logic trig_rd;

  assign sel_slot = mira_pkg::mira_slot(indirect_index); // see RL16
  assign sel_ok = (sel_slot != mira_pkg::SLOT_NONE);
  assign trig_wr = bus.wr && bus.addr == mira_pkg::DEV_OFS_TRIGGER;
  assign trig_rd = bus.rd && bus.addr == mira_pkg::DEV_OFS_TRIGGER;

  // pick the selected slot; an unimplemented index reads as zero
  always_comb begin
    sel_value = 16'h0000; // see RL17
    for (int k = 0; k < mira_pkg::MAC_REG_COUNT; k++) begin
      if (sel_ok && sel_slot == 4'(k)) begin
        sel_value = mac_regs[k];
      end
    end
  end

  // index register, plain read/write
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      indirect_index <= mira_pkg::DEV_BYTE_RST;
    end else if (ce && bus.wr && bus.addr == mira_pkg::DEV_OFS_INDEX) begin
      indirect_index <= bus.wdata; // see RL2
    end
  end

  // trigger keeps what was written so it reads back
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      indirect_transfer_trigger <= mira_pkg::DEV_BYTE_RST;
    end else if (ce && trig_wr) begin
      indirect_transfer_trigger <= bus.wdata;
    end
  end

  // data bytes: a trigger read overrides a direct write, which cannot coincide anyway
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      indirect_data_high <= mira_pkg::DEV_BYTE_RST;
      indirect_data_low <= mira_pkg::DEV_BYTE_RST;
    end else if (ce) begin
      if (trig_rd) begin
        indirect_data_high <= sel_value[15:8]; // see RL6 see RL3
        indirect_data_low <= sel_value[7:0]; // see RL6 see RL4
      end else if (bus.wr && bus.addr == mira_pkg::DEV_OFS_DATA_HIGH) begin
        indirect_data_high <= bus.wdata; // see RL3
      end else if (bus.wr && bus.addr == mira_pkg::DEV_OFS_DATA_LOW) begin
        indirect_data_low <= bus.wdata; // see RL4
      end
    end
  end

  // ==========================================================
  // indirect storage, one slot per register, no direct address
  for (genvar g = 0; g < mira_pkg::MAC_REG_COUNT; g++) begin : g_slot
    always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        mac_regs[g] <= (g == 0) ? mira_pkg::CONTROL_RST : mira_pkg::OTHER_RST; // see RL1
      end else if (ce && trig_wr && sel_ok && sel_slot == 4'(g)) begin
        mac_regs[g] <= {indirect_data_high, indirect_data_low}; // see RL5 see RL17
      end
    end
  end

  // ==========================================================
  // read answer, registered so the trigger-read data is old byte contents
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus.rvalid <= 1'b0;
      bus.rdata <= mira_pkg::DEV_BYTE_RST;
    end else if (ce) begin
      bus.rvalid <= bus.rd;
      // rdata only moves with a read strobe, so it holds between answers
      if (bus.rd) begin
        case (bus.addr)
          mira_pkg::DEV_OFS_INDEX: bus.rdata <= indirect_index;
          mira_pkg::DEV_OFS_DATA_HIGH: bus.rdata <= indirect_data_high;
          mira_pkg::DEV_OFS_DATA_LOW: bus.rdata <= indirect_data_low;
          mira_pkg::DEV_OFS_TRIGGER: bus.rdata <= indirect_transfer_trigger;
          default: bus.rdata <= mira_pkg::DEV_BYTE_RST;
        endcase
      end
    end
  end

endmodule // mira_dev

//--- hw/mira_host.sv
// controller end: apb registers, indirect access sequencer and mac init
// What this block does
// RL1: mac settings live in nine indirect 16-bit registers
// RL2: 8-bit index selects the trigger's target register
// RL3: high data byte carries value bits 15..8
// RL4: low data byte carries value bits 7..0
// RL5: trigger write copies data bytes into target
// RL6: trigger read copies target into data bytes
// RL7: index first, then data and trigger order
// RL8: init after phy ready and each autoneg; an autoneg_done pulse that comes while a sequence runs starts no init
// RL9: mac duplex matches phy before any traffic
// RL10: configuration gets 0x40b3 full, 0x4012 half
// RL11: back-to-back gap 0x0015 full, 0x0012 half
// RL12: non-back-to-back gap gets 0x0c12
// RL13: maximum frame length gets 0x05ee
// RL14: station address into three consecutive words
// RL15: control last, 0x0001 plus optional loopback/flow
// RL16: indices 0x00-0x05 and 0x10-0x12
// RL17: unimplemented index: write ignored, read zero
//
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
module mira_host (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic autoneg_done,
  output logic mac_ready,
  mira_if.host bus
);

  typedef enum logic [3:0] {
    MIRA_IDLE = 4'b0001,
    MIRA_ISSUE = 4'b0010,
    MIRA_WAIT = 4'b0100,
    MIRA_ADV = 4'b1000
  } mira_state_t;
  // ==========================================================
  // declarations
  mira_state_t state;
  logic [mira_pkg::CTRL_WIDTH-1:0] ctrl;
  logic [7:0] req_index, cur_index, tbl_index;
  logic [15:0] req_wdata, read_data, station_hi, cur_value, tbl_value, ctl_value;
  logic [31:0] station_lo;
  logic [2:0] op_num, tbl_op;
  logic [1:0] phase;
  logic done, op_init, op_read, apb_setup, apb_wr, idle, full_duplex, start;
  logic start_init, start_write, start_read, rd_phase, last_phase, seq_end;
  // apb phase decode and duplex selection
  assign apb_setup = psel && !penable;
  assign apb_wr = psel && penable && pready && pwrite;
  assign idle = (state == MIRA_IDLE);
  assign full_duplex = ctrl[mira_pkg::CTRL_FULL_DUPLEX];
  // starts are ignored while a sequence runs; init wins over the others
  assign start_init = idle && ((apb_wr && paddr == mira_pkg::APB_CMD && pwdata[mira_pkg::CMD_INIT])
    || (autoneg_done && ctrl[mira_pkg::CTRL_AUTO_INIT])); // see RL8
  assign start_write = idle && !start_init && apb_wr && paddr == mira_pkg::APB_CMD
    && pwdata[mira_pkg::CMD_WRITE];
  assign start_read = idle && !start_init && !start_write && apb_wr
    && paddr == mira_pkg::APB_CMD && pwdata[mira_pkg::CMD_READ];
  assign start = start_init || start_write || start_read;
  assign rd_phase = op_read && phase != 2'h0;
  assign last_phase = (phase == mira_pkg::PHASE_LAST);
  assign seq_end = last_phase && (!op_init || op_num == mira_pkg::INIT_LAST_OP);
  assign tbl_op = (state == MIRA_ADV) ? op_num + 3'h1 : 3'h0;
  // ==========================================================
  // init table: duplex-dependent values first, control strictly last
  always_comb begin
    ctl_value = mira_pkg::CTL_RCV_EN; // see RL15
    ctl_value[mira_pkg::CTL_LOOPBACK_BIT] = ctrl[mira_pkg::CTRL_LOOPBACK];
    ctl_value[mira_pkg::CTL_TXPAUSE_BIT] = ctrl[mira_pkg::CTRL_TXPAUSE];
    ctl_value[mira_pkg::CTL_RXPAUSE_BIT] = ctrl[mira_pkg::CTRL_RXPAUSE];
  end
  // table lookup by operation number
  always_comb begin
    case (tbl_op)
      3'h0: begin
        tbl_index = mira_pkg::IDX_CONFIG;
        tbl_value = full_duplex ? mira_pkg::CFG_FULL : mira_pkg::CFG_HALF; // see RL10 see RL9
      end
      3'h1: begin
        tbl_index = mira_pkg::IDX_B2B_GAP;
        tbl_value = full_duplex ? mira_pkg::B2B_FULL : mira_pkg::B2B_HALF; // see RL11
      end
      3'h2: begin
        tbl_index = mira_pkg::IDX_NB2B_GAP;
        tbl_value = mira_pkg::NB2B_VALUE; // see RL12
      end
      3'h3: begin
        tbl_index = mira_pkg::IDX_MAX_LEN;
        tbl_value = mira_pkg::MAX_LEN_VALUE; // see RL13
      end
      3'h4: begin
        tbl_index = mira_pkg::IDX_STATION0;
        tbl_value = station_hi; // see RL14
      end
      3'h5: begin
        tbl_index = mira_pkg::IDX_STATION1;
        tbl_value = station_lo[31:16]; // see RL14
      end
      3'h6: begin
        tbl_index = mira_pkg::IDX_STATION2;
        tbl_value = station_lo[15:0]; // see RL14
      end
      default: begin
        tbl_index = mira_pkg::IDX_CONTROL;
        tbl_value = ctl_value; // see RL15
      end
    endcase
  end
  // ==========================================================
  // apb slave: one wait-free access, answer prepared in the setup cycle
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (ce) begin
      pready <= apb_setup;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      if (apb_setup) begin
        case (paddr)
          mira_pkg::APB_CTRL: prdata <= 32'(ctrl);
          mira_pkg::APB_CMD: prdata <= 32'h0000_0000;
          mira_pkg::APB_INDEX: prdata <= 32'(req_index);
          mira_pkg::APB_WDATA: prdata <= 32'(req_wdata);
          mira_pkg::APB_RDATA: prdata <= 32'(read_data);
          mira_pkg::APB_STATUS: prdata <= 32'({mac_ready, done, !idle});
          mira_pkg::APB_STATION_HI: prdata <= 32'(station_hi);
          mira_pkg::APB_STATION_LO: prdata <= station_lo;
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end
  // software-written settings
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= '0;
      req_index <= 8'h00;
      req_wdata <= 16'h0000;
      station_hi <= 16'h0000;
      station_lo <= 32'h0000_0000;
    end else if (ce && apb_wr) begin
      case (paddr)
        mira_pkg::APB_CTRL: ctrl <= pwdata[mira_pkg::CTRL_WIDTH-1:0];
        mira_pkg::APB_INDEX: req_index <= pwdata[7:0];
        mira_pkg::APB_WDATA: req_wdata <= pwdata[15:0];
        mira_pkg::APB_STATION_HI: station_hi <= pwdata[15:0];
        mira_pkg::APB_STATION_LO: station_lo <= pwdata;
        default: ;
      endcase
    end
  end
  // done flag: completion sets, writing one clears, set wins
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      done <= 1'b0;
    end else if (ce) begin
      if (state == MIRA_ADV && seq_end) begin
        done <= 1'b1;
      end else if (apb_wr && paddr == mira_pkg::APB_STATUS && pwdata[mira_pkg::STAT_DONE]) begin
        done <= 1'b0;
      end
    end
  end
  // traffic may only flow once the duplex-matched init has finished
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mac_ready <= 1'b0;
    end else if (ce) begin
      if (start_init) begin
        mac_ready <= 1'b0; // see RL9
      end else if (state == MIRA_ADV && seq_end && op_init) begin
        mac_ready <= 1'b1; // see RL9
      end
    end
  end
  // ==========================================================
  // sequencer state
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= MIRA_IDLE;
    end else if (ce) begin
      case (state)
        MIRA_IDLE: if (start) state <= MIRA_ISSUE;
        MIRA_ISSUE: state <= rd_phase ? MIRA_WAIT : MIRA_ADV;
        MIRA_WAIT: if (bus.rvalid) state <= MIRA_ADV;
        MIRA_ADV: state <= seq_end ? MIRA_IDLE : MIRA_ISSUE;
        default: state <= MIRA_IDLE;
      endcase
    end
  end
  // operation and phase bookkeeping; each op is four byte accesses
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      op_num <= 3'h0;
      phase <= 2'h0;
      op_init <= 1'b0;
      op_read <= 1'b0;
      cur_index <= 8'h00;
      cur_value <= 16'h0000;
    end else if (ce) begin
      if (start) begin
        op_num <= 3'h0;
        phase <= 2'h0;
        op_init <= start_init;
        op_read <= start_read;
        cur_index <= start_init ? tbl_index : req_index;
        cur_value <= start_init ? tbl_value : req_wdata;
      end else if (state == MIRA_ADV && !seq_end) begin
        if (last_phase) begin
          phase <= 2'h0;
          op_num <= tbl_op;
          cur_index <= tbl_index;
          cur_value <= tbl_value;
        end else begin
          phase <= phase + 2'h1;
        end
      end
    end
  end
  // byte strobes: index first, then data bytes and trigger, or trigger then data
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus.wr <= 1'b0;
      bus.rd <= 1'b0;
      bus.addr <= 8'h00;
      bus.wdata <= 8'h00;
    end else if (ce) begin
      bus.wr <= 1'b0;
      bus.rd <= 1'b0;
      if (state == MIRA_ISSUE) begin
        bus.wr <= !rd_phase; // see RL7
        bus.rd <= rd_phase; // see RL7
        case (phase)
          2'h0: begin
            bus.addr <= mira_pkg::DEV_OFS_INDEX; // see RL7
            bus.wdata <= cur_index;
          end
          2'h1: begin
            bus.addr <= op_read ? mira_pkg::DEV_OFS_TRIGGER : mira_pkg::DEV_OFS_DATA_HIGH;
            bus.wdata <= cur_value[15:8];
          end
          2'h2: begin
            bus.addr <= op_read ? mira_pkg::DEV_OFS_DATA_HIGH : mira_pkg::DEV_OFS_DATA_LOW;
            bus.wdata <= cur_value[7:0];
          end
          default: begin
            bus.addr <= op_read ? mira_pkg::DEV_OFS_DATA_LOW : mira_pkg::DEV_OFS_TRIGGER;
            bus.wdata <= 8'h00;
          end
        endcase
      end
    end
  end
  // capture the two data bytes of a read; trigger-read data is dropped
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      read_data <= 16'h0000;
    end else if (ce && state == MIRA_WAIT && bus.rvalid) begin
      if (phase == 2'h2) begin
        read_data[15:8] <= bus.rdata;
      end else if (last_phase) begin
        read_data[7:0] <= bus.rdata;
      end
    end
  end
endmodule // mira_host

//--- verif/mira_chk.sv
// checker on the byte bus that joins the controller end to the device end
`timescale 1ns/1ps
module mira_chk (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic rvalid
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic [7:0] last_wr;
  logic [7:0] last_rd;

  // ==========================================================
  // helper state
  // last offsets written and read, so the order of a transfer can be judged
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      last_wr <= 8'h00;
      last_rd <= 8'h00;
    end else begin
      last_wr <= wr ? addr : last_wr;
      last_rd <= rd ? addr : last_rd;
    end
  end

  // ==========================================================
  // assertions
  chk_read_answer: assert property (rd |=> rvalid)
    else $error("read strobe not answered one cycle later");
  chk_answer_cause: assert property (rvalid |-> $past(rd))
    else $error("read answer without a read strobe");
  chk_rdata_hold: assert property (!rvalid |-> $stable(rdata))
    else $error("read byte moved outside an answer");
  chk_strobe_apart: assert property (!(wr && rd))
    else $error("write and read strobes together");
  chk_write_pulse: assert property (wr |=> !wr)
    else $error("write strobe longer than one cycle");
  chk_read_pulse: assert property (rd |=> !rd)
    else $error("read strobe longer than one cycle");
  chk_trig_wr_order: assert property (wr && addr == mira_pkg::DEV_OFS_TRIGGER
      |-> last_wr == mira_pkg::DEV_OFS_DATA_LOW)
    else $error("trigger written before the data bytes");
  chk_trig_rd_order: assert property (rd && addr == mira_pkg::DEV_OFS_TRIGGER
      |-> last_wr == mira_pkg::DEV_OFS_INDEX)
    else $error("trigger read without a fresh index");
  chk_high_rd_order: assert property (rd && addr == mira_pkg::DEV_OFS_DATA_HIGH
      |-> last_rd == mira_pkg::DEV_OFS_TRIGGER)
    else $error("high byte read before the trigger read");
  chk_low_rd_order: assert property (rd && addr == mira_pkg::DEV_OFS_DATA_LOW
      |-> last_rd == mira_pkg::DEV_OFS_DATA_HIGH)
    else $error("low byte read out of order");
  chk_direct_only: assert property ((wr || rd) |-> addr inside
      {[mira_pkg::DEV_OFS_INDEX:mira_pkg::DEV_OFS_TRIGGER]})
    else $error("strobe outside the four direct registers");

  // ==========================================================
  // coverage of the main transfers
  cov_trig_wr: cover property (wr && addr == mira_pkg::DEV_OFS_TRIGGER);
  cov_trig_rd: cover property (rd && addr == mira_pkg::DEV_OFS_TRIGGER);
  cov_low_answer: cover property (rvalid && last_rd == mira_pkg::DEV_OFS_DATA_LOW);
endmodule // mira_chk

//--- verif/mac_indirect_register_access_test.sv
// self-checking bench: both ends joined, apb stimulus, behavioural register model
`timescale 1ns/1ps
module mac_indirect_register_access_test;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic autoneg_done = 1'b0;
  logic mac_ready;
  logic [mira_pkg::MAC_REG_COUNT-1:0][15:0] mac_regs;
  logic [15:0] model [9];
  logic [31:0] rd_val;
  logic err;
  logic [7:0] idx;
  logic [15:0] val;
  int miscompares = 0;
  int compares = 0;
  int seed = 82;
  int s;
  logic [7:0] idx_tab [13] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h10, 8'h11,
                               8'h12, 8'h06, 8'h0f, 8'h13, 8'hff};

  mira_if bus_if ();
  mira_dev mira_dev_inst (.sys_clk(sys_clk), .rst_n(rst_n), .ce(ce), .bus(bus_if),
    .mac_regs(mac_regs));
  mira_host mira_host_inst (.sys_clk(sys_clk), .rst_n(rst_n), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .autoneg_done(autoneg_done), .mac_ready(mac_ready),
    .bus(bus_if));
  mira_chk mira_chk_inst (.sys_clk(sys_clk), .rst_n(rst_n), .addr(bus_if.addr),
    .wdata(bus_if.wdata), .wr(bus_if.wr), .rd(bus_if.rd), .rdata(bus_if.rdata),
    .rvalid(bus_if.rvalid));

  // 100 MHz clock
  always #5 sys_clk = ~sys_clk;

  // ==========================================================
  // reporting
  task automatic give_verdict();
    if (miscompares == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // own index map: slot of an indirect index, -1 when nothing is there
  function automatic int slot_of(input logic [7:0] i);
    if (i <= 8'h05) return int'(i);
    if (i >= 8'h10 && i <= 8'h12) return int'(i) - 16 + 6;
    return -1;
  endfunction

  task automatic check_regs();
    for (int i = 0; i < 9; i++) begin
      check("mac_reg", {16'h0, mac_regs[i]}, {16'h0, model[i]});
    end
  endtask

  // ==========================================================
  // apb master: hold the request until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    bit got;
    got = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    // pready, prdata and pslverr are taken at the rising edge that ends the access
    for (int n = 0; n < 50 && !got; n++) begin
      @(posedge sys_clk);
      if (pready === 1'b1) begin
        got = 1;
        r = prdata;
        e = pslverr;
      end
    end
    if (!got) begin
      check("pready", 0, 1);
      give_verdict();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr32(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rd_val, err);
    check("pslverr", {31'h0, err}, 0);
  endtask

  // poll status until the sequencer is idle; a dead sequencer ends the run
  task automatic wait_idle();
    bit idle;
    idle = 0;
    for (int n = 0; n < 100 && !idle; n++) begin
      apb(1'b0, mira_pkg::APB_STATUS, 0, rd_val, err);
      idle = (rd_val[mira_pkg::STAT_BUSY] === 1'b0);
    end
    if (!idle) begin
      check("busy", 1, 0);
      give_verdict();
    end
    check("done", {31'h0, rd_val[mira_pkg::STAT_DONE]}, 1);
    // clear done so the next completion has to set it again
    wr32(mira_pkg::APB_STATUS, 32'h2);
  endtask

  // expected image of a full init, control value last
  task automatic init_model(input bit full, input logic [15:0] ctl, input logic [47:0] sta);
    model[1] = full ? 16'h40b3 : 16'h4012;
    model[2] = full ? 16'h0015 : 16'h0012;
    model[3] = 16'h0c12;
    model[5] = 16'h05ee;
    model[6] = sta[47:32];
    model[7] = sta[31:16];
    model[8] = sta[15:0];
    model[0] = ctl;
  endtask

  // ==========================================================
  // main sequence
  initial begin
    for (int i = 0; i < 9; i++) model[i] = (i == 0) ? 16'h8000 : 16'h0000;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    check_regs();
    apb(1'b0, mira_pkg::APB_STATUS, 0, rd_val, err);
    check("status_rst", rd_val, 0);
    apb(1'b0, 8'h20, 0, rd_val, err);
    check("pslverr_unmapped", {31'h0, err}, 1);
    // random indirect writes then read-back, unimplemented indices included
    for (int k = 0; k < 26; k++) begin
      s = $random(seed);
      idx = (k < 13) ? idx_tab[k] : idx_tab[(s & 32'hffff) % 13];
      val = s[31:16];
      wr32(mira_pkg::APB_INDEX, {24'h0, idx});
      wr32(mira_pkg::APB_WDATA, {16'h0, val});
      wr32(mira_pkg::APB_CMD, 32'h2);
      wait_idle();
      if (slot_of(idx) >= 0) model[slot_of(idx)] = val;
      check_regs();
      wr32(mira_pkg::APB_CMD, 32'h4);
      wait_idle();
      apb(1'b0, mira_pkg::APB_RDATA, 0, rd_val, err);
      check("rdata", rd_val, (slot_of(idx) >= 0) ? {16'h0, model[slot_of(idx)]} : 0);
    end
    // full duplex init by command, loopback and rx flow control on
    wr32(mira_pkg::APB_STATION_HI, 32'h0000a1b2);
    wr32(mira_pkg::APB_STATION_LO, 32'hc3d4e5f6);
    wr32(mira_pkg::APB_CTRL, 32'h15);
    wr32(mira_pkg::APB_CMD, 32'h1);
    wait_idle();
    init_model(1, 16'h0015, 48'ha1b2_c3d4_e5f6);
    check_regs();
    check("mac_ready", {31'h0, mac_ready}, 1);
    // half duplex init started by the auto-negotiation pulse
    wr32(mira_pkg::APB_CTRL, 32'h2);
    @(posedge sys_clk);
    autoneg_done <= 1'b1;
    @(posedge sys_clk);
    autoneg_done <= 1'b0;
    @(posedge sys_clk);
    check("mac_ready_busy", {31'h0, mac_ready}, 0);
    wait_idle();
    init_model(0, 16'h0001, 48'ha1b2_c3d4_e5f6);
    check_regs();
    apb(1'b0, mira_pkg::APB_CTRL, 0, rd_val, err);
    check("ctrl", rd_val, 32'h2);
    give_verdict();
  end
endmodule // mac_indirect_register_access_test
